// [ssd_pkg.sv]
// Shared SFR address decode: constants and types
package ssd_pkg;

    // Bus geometry
    localparam int ADDR_W = 14;
    localparam int IDX_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_WATCHDOG_CONTROL = 12'hfc0;
    localparam logic [11:0] IDX_SERIAL_SLAVE_ADDRESS = 12'hfc8;
    localparam logic [11:0] IDX_PORT_PAIR_HIGH = 12'hf69;
    localparam logic [11:0] IDX_PORT_PAIR_LOW = 12'hf68;

    // Shared addresses: default / alternate pairs
    localparam int NUM_SHARED = 9;
    localparam logic [11:0] SHARED_IDX [0:8] = '{
        12'hf77,  // timer4_period / comparator_reference_control
        12'hfc1,  // converter_control_1 / analog_select_low
        12'hfc2,  // converter_control_0 / analog_select_high
        12'hfcb,  // timer2_period / external_memory_config
        12'hfcc,  // timer2_count / pad_config
        12'hfcd,  // timer1_control / open_drain_control_3
        12'hfce,  // timer1_count_low / open_drain_control_2
        12'hfcf,  // timer1_count_high / open_drain_control_1
        12'hfd3   // oscillator_control / reference_clock_out_control
    };
    localparam int EXT_MEM_SLOT = 3;

    // Watchdog control field positions
    localparam int BIT_REGULATOR_LP = 7;
    localparam int BIT_LOW_VOLTAGE = 6;
    localparam int BIT_SHARED_SELECT = 4;
    localparam int BIT_SOFT_WATCHDOG = 0;

    // Values after reset
    localparam logic [7:0] SFR_RESET = 8'h00;
    localparam logic [7:0] PAIR_RESET = 8'h00;

    // Answer codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic regulator_low_power_en;
        logic shared_addr_select;
        logic soft_watchdog_en;
    } ssd_wdt_type;

    typedef struct packed {
        logic en;
        logic [11:0] idx;
        logic [7:0] data;
    } ssd_access_type;

endpackage : ssd_pkg

// [ssd_sync2.sv]
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module ssd_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,                // Core clock
    input wire logic aresetn,             // Sync reset, active low
    input wire logic [WIDTH-1:0] async_in, // Level from outside the domain
    output logic [WIDTH-1:0] sync_out     // Level safe to read
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds the second and nothing else
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : ssd_sync2
`default_nettype wire

// [ssd_sfr_pair.sv]
// Two hardware registers behind one address, steered by a select
`timescale 1ns/1ps
`default_nettype none
module ssd_sfr_pair #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter bit HAS_ALT = 1'b1
) (
    input wire logic aclk,        // Core clock
    input wire logic aresetn,     // Sync reset, active low
    input wire logic alt_sel,     // High: alternate register
    input wire logic wr_en,       // Write strobe for this address
    input wire logic [7:0] wdata, // Write byte
    output logic [7:0] rdata,     // Byte of the selected register
    output logic [7:0] default_q, // Default register contents
    output logic [7:0] alt_q      // Alternate register contents
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            default_q <= RESET_VALUE;
        end else if (wr_en && !alt_sel) begin
            default_q <= wdata;
        end
    end

    generate
        if (HAS_ALT) begin : g_alt
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    alt_q <= RESET_VALUE;
                end else if (wr_en && alt_sel) begin
                    alt_q <= wdata;
                end
            end
        end else begin : g_no_alt
            // Absent register: reads zero, writes dropped
            assign alt_q = 8'h00;
        end
    endgenerate

    assign rdata = alt_sel ? alt_q : default_q;
endmodule : ssd_sfr_pair
`default_nettype wire

// [ssd_shared_decode.sv]
// Shared SFR address decode with watchdog control, AXI4-Lite slave
//
// Contract
// - Select bit 4 writable, clears at reset
// - Select zero: shared address hits default
// - Select one: shared address hits alternate
// - Memory config exists only on large variant
// - Context pairs ignore the select bit
// - Serial mode picks slave address or mask
// - Port address/output pair: one physical set
// - Bit 6 shows core voltage, read-only
// - Bits 5 and 3..1 read zero
// - Soft watchdog enable bit 0, clears
// - Regulator low-power bit 7, clears
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ssd_shared_decode #(
    parameter bit EXT_MEM_PRESENT = 1'b1
) (
    input wire logic aclk,                             // Core clock, 50 MHz
    input wire logic aresetn,                          // Sync reset, active low
    input wire logic [ssd_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid,                    // Write address valid
    output logic s_axi_awready,                        // Write address ready
    input wire logic [31:0] s_axi_wdata,               // Write data
    input wire logic [3:0] s_axi_wstrb,                // Write strobes
    input wire logic s_axi_wvalid,                     // Write data valid
    output logic s_axi_wready,                         // Write data ready
    output logic [1:0] s_axi_bresp,                    // Write response
    output logic s_axi_bvalid,                         // Write response valid
    input wire logic s_axi_bready,                     // Write response ready
    input wire logic [ssd_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid,                    // Read address valid
    output logic s_axi_arready,                        // Read address ready
    output logic [31:0] s_axi_rdata,                   // Read data
    output logic [1:0] s_axi_rresp,                    // Read response
    output logic s_axi_rvalid,                         // Read data valid
    input wire logic s_axi_rready,                     // Read data ready
    input wire logic core_voltage_ok,                  // Async: core supply above threshold
    input wire logic serial_mask_mode,                 // Serial module in mask mode
    input wire logic parallel_slave_mode,              // Parallel port in slave mode
    output logic regulator_low_power_en,               // Regulator low-power enable
    output logic soft_watchdog_en,                     // Software watchdog enable
    output logic shared_addr_select,                   // Alternate registers selected
    output logic [7:0] serial_slave_address,           // Serial slave address
    output logic [7:0] serial_address_mask,            // Serial address mask
    output logic [15:0] parallel_port_word             // Port address or output data
);

    ////////////////////////////////////////////////////////////////////////
    // Write channel capture

    logic aw_have_reg;
    logic w_have_reg;
    logic [11:0] aw_idx_reg;
    logic [7:0] w_byte_reg;
    logic w_lane_reg;
    ssd_pkg::ssd_access_type wr_acc;
    logic wr_hit;

    assign wr_acc.en = aw_have_reg && w_have_reg && !s_axi_bvalid && w_lane_reg;
    assign wr_acc.idx = aw_idx_reg;
    assign wr_acc.data = w_byte_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            aw_idx_reg <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[ssd_pkg::ADDR_W-1:2];
        end else if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
            aw_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_reg <= 1'b0;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_byte_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
        end else if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
            w_have_reg <= 1'b0;
        end
    end

    // One write in flight; the channels are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ssd_pkg::RESP_OKAY;
        end else if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? ssd_pkg::RESP_OKAY : ssd_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog control register

    ssd_pkg::ssd_wdt_type wdt_reg;
    logic wdt_wr;
    logic low_voltage_status;

    assign wdt_wr = wr_acc.en && wr_acc.idx == ssd_pkg::IDX_WATCHDOG_CONTROL;

    // Unimplemented bits are simply not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_reg <= '0;
        end else if (wdt_wr) begin
            wdt_reg.regulator_low_power_en <= wr_acc.data[ssd_pkg::BIT_REGULATOR_LP];
            wdt_reg.shared_addr_select <= wr_acc.data[ssd_pkg::BIT_SHARED_SELECT];
            wdt_reg.soft_watchdog_en <= wr_acc.data[ssd_pkg::BIT_SOFT_WATCHDOG];
        end
    end

    assign regulator_low_power_en = wdt_reg.regulator_low_power_en;
    assign soft_watchdog_en = wdt_reg.soft_watchdog_en;
    assign shared_addr_select = wdt_reg.shared_addr_select;

    // Supply comparator is analog and asynchronous
    ssd_sync2 #(.WIDTH(1)) u_lvd_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(core_voltage_ok),
        .sync_out(low_voltage_status)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shared address pairs

    logic [7:0] pair_rdata [0:ssd_pkg::NUM_SHARED-1];
    logic [7:0] pair_def [0:ssd_pkg::NUM_SHARED-1];
    logic [7:0] pair_alt [0:ssd_pkg::NUM_SHARED-1];
    logic [ssd_pkg::NUM_SHARED-1:0] pair_wr;

    generate
        for (genvar i = 0; i < ssd_pkg::NUM_SHARED; i++) begin : g_pair
            // Steering uses the stored select, so a new value governs the next access
            assign pair_wr[i] = wr_acc.en && wr_acc.idx == ssd_pkg::SHARED_IDX[i];
            ssd_sfr_pair #(
                .RESET_VALUE(ssd_pkg::PAIR_RESET),
                .HAS_ALT((i == ssd_pkg::EXT_MEM_SLOT) ? EXT_MEM_PRESENT : 1'b1)
            ) u_pair (
                .aclk(aclk),
                .aresetn(aresetn),
                .alt_sel(wdt_reg.shared_addr_select),
                .wr_en(pair_wr[i]),
                .wdata(wr_acc.data),
                .rdata(pair_rdata[i]),
                .default_q(pair_def[i]),
                .alt_q(pair_alt[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Context-defined registers

    logic ctx_serial_wr;
    logic port_high_wr;
    logic port_low_wr;

    assign ctx_serial_wr = wr_acc.en && wr_acc.idx == ssd_pkg::IDX_SERIAL_SLAVE_ADDRESS;
    assign port_high_wr = wr_acc.en && wr_acc.idx == ssd_pkg::IDX_PORT_PAIR_HIGH;
    assign port_low_wr = wr_acc.en && wr_acc.idx == ssd_pkg::IDX_PORT_PAIR_LOW;

    // Two registers, one address; select bit plays no part
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_slave_address <= ssd_pkg::SFR_RESET;
            serial_address_mask <= ssd_pkg::SFR_RESET;
        end else if (ctx_serial_wr) begin
            if (serial_mask_mode) begin
                serial_address_mask <= wr_acc.data;
            end else begin
                serial_slave_address <= wr_acc.data;
            end
        end
    end

    // One physical pair; mode only changes what the port does with it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            parallel_port_word <= {ssd_pkg::SFR_RESET, ssd_pkg::SFR_RESET};
        end else begin
            if (port_high_wr) begin
                parallel_port_word[15:8] <= wr_acc.data;
            end
            if (port_low_wr) begin
                parallel_port_word[7:0] <= wr_acc.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode hit for writes and read mux

    logic [11:0] ar_idx;
    logic rd_hit;
    logic [7:0] rd_byte;

    assign ar_idx = s_axi_araddr[ssd_pkg::ADDR_W-1:2];

    always_comb begin
        wr_hit = 1'b0;
        for (int i = 0; i < ssd_pkg::NUM_SHARED; i++) begin
            if (aw_idx_reg == ssd_pkg::SHARED_IDX[i]) begin
                wr_hit = 1'b1;
            end
        end
        if (aw_idx_reg == ssd_pkg::IDX_WATCHDOG_CONTROL || aw_idx_reg == ssd_pkg::IDX_SERIAL_SLAVE_ADDRESS ||
            aw_idx_reg == ssd_pkg::IDX_PORT_PAIR_HIGH || aw_idx_reg == ssd_pkg::IDX_PORT_PAIR_LOW) begin
            wr_hit = 1'b1;
        end
    end

    always_comb begin
        rd_hit = 1'b0;
        rd_byte = 8'h00;
        for (int i = 0; i < ssd_pkg::NUM_SHARED; i++) begin
            if (ar_idx == ssd_pkg::SHARED_IDX[i]) begin
                rd_hit = 1'b1;
                rd_byte = pair_rdata[i];
            end
        end
        unique case (ar_idx)
            ssd_pkg::IDX_WATCHDOG_CONTROL: begin
                rd_hit = 1'b1;
                rd_byte = {wdt_reg.regulator_low_power_en, low_voltage_status, 1'b0,
                           wdt_reg.shared_addr_select, 3'h0, wdt_reg.soft_watchdog_en};
            end
            ssd_pkg::IDX_SERIAL_SLAVE_ADDRESS: begin
                rd_hit = 1'b1;
                rd_byte = serial_mask_mode ? serial_address_mask : serial_slave_address;
            end
            ssd_pkg::IDX_PORT_PAIR_HIGH: begin
                rd_hit = 1'b1;
                rd_byte = parallel_port_word[15:8];
            end
            ssd_pkg::IDX_PORT_PAIR_LOW: begin
                rd_hit = 1'b1;
                rd_byte = parallel_port_word[7:0];
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    logic [11:0] rd_idx_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ssd_pkg::RESP_OKAY;
            rd_idx_reg <= 12'h000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? ssd_pkg::RESP_OKAY : ssd_pkg::RESP_SLVERR;
            rd_idx_reg <= ar_idx;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_select_reset;
        @(posedge aclk) !aresetn |=> !shared_addr_select && !soft_watchdog_en && !regulator_low_power_en;
    endproperty
    a_select_reset: assert property (p_select_reset) else $error("watchdog control not cleared by reset");

    property p_default_only;
        @(posedge aclk) disable iff (!aresetn)
            (pair_wr[0] && !shared_addr_select) |=> pair_alt[0] == $past(pair_alt[0]) &&
                pair_def[0] == $past(wr_acc.data);
    endproperty
    a_default_only: assert property (p_default_only) else $error("default write leaked to alternate");

    property p_alt_only;
        @(posedge aclk) disable iff (!aresetn)
            (pair_wr[8] && shared_addr_select) |=> pair_def[8] == $past(pair_def[8]) &&
                pair_alt[8] == $past(wr_acc.data);
    endproperty
    a_alt_only: assert property (p_alt_only) else $error("alternate write leaked to default");

    property p_no_ext_mem;
        @(posedge aclk) disable iff (!aresetn)
            !EXT_MEM_PRESENT |-> pair_alt[ssd_pkg::EXT_MEM_SLOT] == 8'h00;
    endproperty
    a_no_ext_mem: assert property (p_no_ext_mem) else $error("memory config present on small variant");

    property p_serial_mode;
        @(posedge aclk) disable iff (!aresetn)
            (ctx_serial_wr && serial_mask_mode) |=> serial_address_mask == $past(wr_acc.data) &&
                $stable(serial_slave_address);
    endproperty
    a_serial_mode: assert property (p_serial_mode) else $error("mask write went astray");

    property p_port_pair;
        @(posedge aclk) disable iff (!aresetn)
            port_low_wr |=> parallel_port_word[7:0] == $past(wr_acc.data) && $stable(parallel_port_word[15:8]);
    endproperty
    a_port_pair: assert property (p_port_pair) else $error("port pair write lost");

    property p_wdt_readback;
        @(posedge aclk) disable iff (!aresetn)
            (s_axi_rvalid && rd_idx_reg == ssd_pkg::IDX_WATCHDOG_CONTROL) |->
                s_axi_rdata[5] == 1'b0 && s_axi_rdata[3:1] == 3'h0 && s_axi_rdata[31:8] == 24'h00_0000;
    endproperty
    a_wdt_readback: assert property (p_wdt_readback) else $error("unimplemented bits read nonzero");

    property p_lvd_follow;
        @(posedge aclk) disable iff (!aresetn)
            (s_axi_arvalid && s_axi_arready && ar_idx == ssd_pkg::IDX_WATCHDOG_CONTROL) |=>
                s_axi_rdata[ssd_pkg::BIT_LOW_VOLTAGE] == $past(low_voltage_status);
    endproperty
    a_lvd_follow: assert property (p_lvd_follow) else $error("voltage status bit wrong");

    property p_wdt_write;
        @(posedge aclk) disable iff (!aresetn)
            wdt_wr |=> soft_watchdog_en == $past(wr_acc.data[0]) && regulator_low_power_en == $past(wr_acc.data[7]);
    endproperty
    a_wdt_write: assert property (p_wdt_write) else $error("watchdog control write lost");

    property p_select_now;
        @(posedge aclk) disable iff (!aresetn)
            wdt_wr |=> shared_addr_select == $past(wr_acc.data[ssd_pkg::BIT_SHARED_SELECT]);
    endproperty
    a_select_now: assert property (p_select_now) else $error("select change delayed");

    property p_write_answer;
        @(posedge aclk) disable iff (!aresetn)
            (aw_have_reg && w_have_reg && !s_axi_bvalid) |=> s_axi_bvalid ##0 (!aw_have_reg && !w_have_reg);
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response late");

endmodule : ssd_shared_decode
`default_nettype wire

// [ssd_shared_decode_bench.sv]
// Self-checking bench for the shared SFR address decode block
`timescale 1ns/1ps
`default_nettype none
module ssd_shared_decode_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [13:0] s_axi_awaddr = 14'h0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [13:0] s_axi_araddr = 14'h0000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic core_voltage_ok = 1'b0;
    logic serial_mask_mode = 1'b0;
    logic parallel_slave_mode = 1'b0;
    logic regulator_low_power_en;
    logic soft_watchdog_en;
    logic shared_addr_select;
    logic [7:0] serial_slave_address;
    logic [7:0] serial_address_mask;
    logic [15:0] parallel_port_word;
    logic [31:0] small_rdata;
    logic alt_mode = 1'b0;
    int fails = 0;
    int n_tests = 0;
    localparam logic [11:0] WD = ssd_pkg::IDX_WATCHDOG_CONTROL;
    localparam logic [11:0] SER = ssd_pkg::IDX_SERIAL_SLAVE_ADDRESS;
    localparam logic [1:0] OK = ssd_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = ssd_pkg::RESP_SLVERR;

    always #10 aclk = ~aclk;

    ssd_shared_decode dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .core_voltage_ok(core_voltage_ok), .serial_mask_mode(serial_mask_mode),
        .parallel_slave_mode(parallel_slave_mode), .regulator_low_power_en(regulator_low_power_en),
        .soft_watchdog_en(soft_watchdog_en), .shared_addr_select(shared_addr_select),
        .serial_slave_address(serial_slave_address), .serial_address_mask(serial_address_mask),
        .parallel_port_word(parallel_port_word));

    // Small variant without the memory config register, fed the same traffic
    ssd_shared_decode #(.EXT_MEM_PRESENT(1'b0)) dut_small (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
        .s_axi_rdata(small_rdata), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
        .core_voltage_ok(core_voltage_ok), .serial_mask_mode(serial_mask_mode),
        .parallel_slave_mode(parallel_slave_mode), .regulator_low_power_en(), .soft_watchdog_en(),
        .shared_addr_select(), .serial_slave_address(), .serial_address_mask(), .parallel_port_word());

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // Each task opens on a fresh edge so a handshake signal is never set twice in one step
    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        // Bench copy of the select bit, so the small variant's reads can be predicted
        if (idx == WD && s_axi_wstrb[0]) begin
            alt_mode = d[ssd_pkg::BIT_SHARED_SELECT];
        end
    endtask : wr

    task automatic rd(input logic [11:0] idx, input logic [7:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h0, ed}, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        chk("small_rdata", {24'h0, ((alt_mode && idx == ssd_pkg::SHARED_IDX[ssd_pkg::EXT_MEM_SLOT]) ? 8'h00 : ed)},
            small_rdata);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        fails++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(WD, 8'h00, OK);
        core_voltage_ok <= 1'b1;
        // Synchroniser needs two edges before bit 6 follows the supply flag
        repeat (4) @(posedge aclk);
        wr(WD, 8'hff, OK);
        rd(WD, 8'hd1, OK);
        chk("ctl_outs", 32'h7, {29'h0, regulator_low_power_en, shared_addr_select, soft_watchdog_en});
        wr(WD, 8'h00, OK);
        rd(WD, 8'h40, OK);
        $display("test watchdog control done");
        for (int i = 0; i < ssd_pkg::NUM_SHARED; i++) wr(ssd_pkg::SHARED_IDX[i], 8'h10 + i[7:0], OK);
        wr(WD, 8'h10, OK);
        for (int i = 0; i < ssd_pkg::NUM_SHARED; i++) rd(ssd_pkg::SHARED_IDX[i], 8'h00, OK);
        for (int i = 0; i < ssd_pkg::NUM_SHARED; i++) wr(ssd_pkg::SHARED_IDX[i], 8'h80 + i[7:0], OK);
        for (int i = 0; i < ssd_pkg::NUM_SHARED; i++) rd(ssd_pkg::SHARED_IDX[i], 8'h80 + i[7:0], OK);
        wr(WD, 8'h00, OK);
        for (int i = 0; i < ssd_pkg::NUM_SHARED; i++) rd(ssd_pkg::SHARED_IDX[i], 8'h10 + i[7:0], OK);
        $display("test shared addresses done");
        wr(SER, 8'h5a, OK);
        serial_mask_mode <= 1'b1;
        wr(SER, 8'ha5, OK);
        chk("serial_regs", 32'h5aa5, {16'h0, serial_slave_address, serial_address_mask});
        wr(WD, 8'h10, OK);
        rd(SER, 8'ha5, OK);
        serial_mask_mode <= 1'b0;
        rd(SER, 8'h5a, OK);
        $display("test serial context pair done");
        wr(ssd_pkg::IDX_PORT_PAIR_HIGH, 8'h12, OK);
        wr(ssd_pkg::IDX_PORT_PAIR_LOW, 8'h34, OK);
        parallel_slave_mode <= 1'b1;
        rd(ssd_pkg::IDX_PORT_PAIR_HIGH, 8'h12, OK);
        chk("port_word", 32'h1234, {16'h0, parallel_port_word});
        $display("test port pair done");
        // Lane 0 strobe low: the whole write is dropped but still answered
        s_axi_wstrb <= 4'h0;
        wr(WD, 8'h81, OK);
        s_axi_wstrb <= 4'h1;
        rd(WD, 8'h50, OK);
        wr(12'h001, 8'hff, ERR);
        rd(12'h001, 8'h00, ERR);
        $display("test unmapped access done");
        complete_run();
    end
endmodule : ssd_shared_decode_bench
`default_nettype wire
